/* File: rsh_map.svh */
// register offsets, field positions, reset values and counts of the reference select block
`ifndef RSH_MAP_SVH
`define RSH_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define RSH_OFF_CTRL 8'h00
`define RSH_OFF_PRIO 8'h04
`define RSH_OFF_HOLDOFF 8'h08
`define RSH_OFF_LOCKCFG 8'h0c
`define RSH_OFF_STATUS 8'h10
`define RSH_OFF_STICKY 8'h14

// ****************************************
// field widths and positions
// ****************************************
`define RSH_PRE_W 16
`define RSH_CTRL_MODE 0
`define RSH_CTRL_SEL 2
`define RSH_CTRL_REVERT 4
`define RSH_CTRL_VMASK 5
`define RSH_CTRL_SMASK 6
`define RSH_HO_START 0
`define RSH_HO_PRESCALE 8
`define RSH_LC_REVAL 0
`define RSH_LC_WSTART 8
`define RSH_LC_WEND 12
`define RSH_ST_REFVALID 4
`define RSH_ACTIVE_INPUT_CODE 5
`define RSH_ST_HOLD 7
`define RSH_ST_VLOST 8
`define RSH_ST_SLOST 9
`define RSH_ST_COUNT 16
`define RSH_SK_REF 4
`define RSH_SK_VLOST 5
`define RSH_SK_SLOST 6

// ****************************************
// reset values and counts
// ****************************************
`define RSH_RST_PRESCALE 16'h0001
`define RSH_RST_START 8'h00
`define RSH_RST_REVAL 8'h04
`define RSH_RST_WINDOW 3'h7
`define RSH_LOS_MISSES 2'h3
`define RSH_WIN_MIN 3'h2

`endif

/* File: rsh_pkg.sv */
// types of the reference select and holdover block
`include "rsh_map.svh"
package rsh_pkg;

  typedef enum logic [1:0] {
    RSH_MANUAL,
    RSH_AUTO,
    RSH_SHORT_HOLD,
    RSH_AUTO_HOLD
  } rsh_mode_type;

  typedef enum logic [1:0] {
    RSH_RUN,
    RSH_HOLD,
    RSH_COUNT,
    RSH_LOST
  } rsh_fsm_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rsh_bus_type;

  typedef struct packed {
    logic [3:0] clk_in;
    logic los_ref_tick;
    logic vcxo_tick;
    logic feedback_edge;
    logic synth_lock_lost;
  } rsh_pins_type;

  typedef struct packed {
    rsh_mode_type mode;
    logic [1:0] man_sel;
    logic revert_enable;
    logic vcxo_lock_report_mask;
    logic synth_lock_report_mask;
    logic [3:0][1:0] prio;
    logic [`RSH_PRE_W-1:0] holdoff_prescale;
    logic [7:0] holdoff_start_value;
    logic [7:0] revalidation_count;
    logic [2:0] window_start_setting;
    logic [2:0] window_end_setting;
    logic [3:0] in_prev;
    logic tick_prev;
    logic vtick_prev;
    logic fb_prev;
    logic [3:0][1:0] miss;
    logic [3:0][7:0] good;
    logic [3:0] input_valid_live;
    logic [3:0] input_loss_sticky;
    logic [1:0] active_input_code;
    logic ref_valid_live;
    logic ref_loss_sticky;
    rsh_fsm_type fsm;
    logic [`RSH_PRE_W-1:0] pre_cnt;
    logic [7:0] hold_cnt;
    logic [6:0] ref_since_fb;
    logic [6:0] fb_since_ref;
    logic vcxo_lock_lost_live;
    logic vcxo_lock_lost_sticky;
    logic synth_lock_lost_live;
    logic synth_lock_lost_sticky;
    logic lock_q;
    logic int_n_q;
    logic freeze_q;
    logic [31:0] rdata;
  } rsh_state_type;

endpackage : rsh_pkg

/* File: rsh_ctrl.sv */
// reference input selection, holdover and lock detect controller
`timescale 1ns/1ps
`include "rsh_map.svh"

// Summary of operation
// - each of four inputs holds a two-bit priority, 0 lowest, 3 highest
// - priorities writable any time; auto modes reselect at once, except during the holdover countdown
// - hold-off countdown starts on reference loss, expiry reselects and reloads
// - 8-bit hold-off counter ticked by prescaled vcxo clock, start up to ff
// - an input raises no new loss event until its sticky bit is cleared
// - prescaler runs only in auto-with-holdover after loss of selected input
// - revertive: revalidated non-selected input wins only with higher priority
// - revertive off leaves selection alone; off after reset
// - short holdover: loss of designated input enters holdover, status low
// - short holdover: revalidation ends holdover, live status back to one
// - auto-with-holdover: loss of active input holds over and starts countdown
// - all inputs stay monitored during countdown with live and sticky flags
// - active input revalidated during countdown keeps selection, ignores revert
// - at expiry a revalidated active input stays selected, holdover ends
// - at expiry another valid input of top priority is chosen
// - at expiry with none valid stay in holdover, sticky clear refused
// - revertive switching resumes after countdown only if enabled
// - vcxo lock loss outside window shown live and sticky
// - vcxo lock report mask removes vcxo status from lock pin
// - window opens before reference edge, closes after it, feedback inside
// - window bound setting k from 2 to 7 gives 2^k-1 periods
// - synthesizer lock loss live, sticky, on lock pin and interrupt
// - three missing edges against the loss reference divide mark input invalid
// - input valid again after revalidation count edges, the count cleared only by three missing edges
// - auto mode: loss of selected switches to best valid, none means stay
// - manual mode follows manual select field only
module rsh_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire rsh_pkg::rsh_bus_type bus,
  output logic [31:0] rdata,
  // reference inputs and loop signals
  input wire rsh_pkg::rsh_pins_type pins,
  // status pins and holdover control
  output logic [1:0] active_input_code,
  output logic holdover_freeze,
  output logic lock_pin,
  output logic interrupt_pin_n
);
  import rsh_pkg::*;

  // ****************************************
  // helper functions
  // ****************************************
  // best valid input, ties go to the lowest index
  function automatic logic [2:0] best_pick(input logic [3:0] vld, input logic [3:0][1:0] pr);
    logic [2:0] res;
    logic [1:0] top;
    res = 3'h0;
    top = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (vld[i] && (!res[2] || pr[i] > top)) begin
        res = {1'b1, 2'(i)};
        top = pr[i];
      end
    end
    return res;
  endfunction : best_pick

  // window bound from a three-bit setting
  function automatic logic [6:0] win_bound(input logic [2:0] k);
    logic [2:0] kk;
    kk = (k < `RSH_WIN_MIN) ? `RSH_WIN_MIN : k;
    // two to the k minus one
    return 7'((8'h01 << kk) - 8'h01);
  endfunction : win_bound

  rsh_state_type s_reg;
  rsh_state_type s_next;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [3:0] edge_in;
    logic tick;
    logic vtick;
    logic fb_edge;
    logic ref_edge;
    logic [3:0] reval;
    logic [3:0] lost;
    logic [2:0] best;
    logic prio_wr;
    logic expire;
    logic [31:0] rd_word;
    s_next = s_reg;
    edge_in = pins.clk_in & ~s_reg.in_prev;
    tick = pins.los_ref_tick & ~s_reg.tick_prev;
    vtick = pins.vcxo_tick & ~s_reg.vtick_prev;
    fb_edge = pins.feedback_edge & ~s_reg.fb_prev;
    ref_edge = edge_in[s_reg.active_input_code];
    reval = 4'h0;
    lost = 4'h0;
    prio_wr = 1'b0;
    expire = 1'b0;
    best = 3'h0;
    rd_word = 32'h0;
    s_next.in_prev = pins.clk_in;
    s_next.tick_prev = pins.los_ref_tick;
    s_next.vtick_prev = pins.vcxo_tick;
    s_next.fb_prev = pins.feedback_edge;

    // register writes
    if (bus.wr) begin
      case (bus.addr)
        `RSH_OFF_CTRL: begin
          s_next.mode = rsh_mode_type'(bus.wdata[`RSH_CTRL_MODE +: 2]);
          s_next.man_sel = bus.wdata[`RSH_CTRL_SEL +: 2];
          s_next.revert_enable = bus.wdata[`RSH_CTRL_REVERT];
          s_next.vcxo_lock_report_mask = bus.wdata[`RSH_CTRL_VMASK];
          s_next.synth_lock_report_mask = bus.wdata[`RSH_CTRL_SMASK];
        end
        `RSH_OFF_PRIO: begin
          s_next.prio = bus.wdata[7:0];
          prio_wr = 1'b1;
        end
        `RSH_OFF_HOLDOFF: begin
          s_next.holdoff_start_value = bus.wdata[`RSH_HO_START +: 8];
          s_next.holdoff_prescale = bus.wdata[`RSH_HO_PRESCALE +: `RSH_PRE_W];
        end
        `RSH_OFF_LOCKCFG: begin
          s_next.revalidation_count = bus.wdata[`RSH_LC_REVAL +: 8];
          s_next.window_start_setting = bus.wdata[`RSH_LC_WSTART +: 3];
          s_next.window_end_setting = bus.wdata[`RSH_LC_WEND +: 3];
        end
        `RSH_OFF_STICKY: begin
          s_next.input_loss_sticky = s_reg.input_loss_sticky & ~bus.wdata[3:0];
          s_next.vcxo_lock_lost_sticky = s_reg.vcxo_lock_lost_sticky & ~bus.wdata[`RSH_SK_VLOST];
          s_next.synth_lock_lost_sticky = s_reg.synth_lock_lost_sticky & ~bus.wdata[`RSH_SK_SLOST];
        end
        default: begin
        end
      endcase
    end

    // ****************************************
    // input activity monitors
    // ****************************************
    for (int i = 0; i < 4; i++) begin
      if (edge_in[i]) begin
        s_next.miss[i] = 2'h0;
        if (!s_reg.input_valid_live[i]) begin
          s_next.good[i] = s_reg.good[i] + 8'h01;
          if (s_reg.good[i] + 8'h01 >= s_reg.revalidation_count) begin
            s_next.input_valid_live[i] = 1'b1;
            s_next.good[i] = 8'h0;
            reval[i] = 1'b1;
          end
        end
      end else if (tick) begin
        if (s_reg.miss[i] + 2'h1 == `RSH_LOS_MISSES) begin
          s_next.good[i] = 8'h0;
          if (s_reg.input_valid_live[i]) begin
            s_next.input_valid_live[i] = 1'b0;
            lost[i] = 1'b1;
          end
        end else if (s_reg.miss[i] != `RSH_LOS_MISSES) begin
          s_next.miss[i] = s_reg.miss[i] + 2'h1;
        end
      end
      if (lost[i] && !s_reg.input_loss_sticky[i]) begin
        s_next.input_loss_sticky[i] = 1'b1;
      end
    end

    // ****************************************
    // selection state machine
    // ****************************************
    best = best_pick(s_next.input_valid_live, s_next.prio);
    case (s_next.mode)
      RSH_MANUAL: begin
        s_next.active_input_code = s_next.man_sel;
        s_next.fsm = RSH_RUN;
        s_next.ref_valid_live = s_next.input_valid_live[s_next.man_sel];
      end
      RSH_SHORT_HOLD: begin
        s_next.active_input_code = s_next.man_sel;
        s_next.fsm = s_next.input_valid_live[s_next.man_sel] ? RSH_RUN : RSH_HOLD;
        s_next.ref_valid_live = s_next.input_valid_live[s_next.man_sel];
      end
      RSH_AUTO: begin
        s_next.fsm = RSH_RUN;
        if (!s_next.input_valid_live[s_reg.active_input_code] && best[2]) begin
          s_next.active_input_code = best[1:0];
        end
        if (best[2] && (prio_wr || (s_reg.revert_enable && (|(reval & ~(4'h1 << s_reg.active_input_code)))))
            && s_next.prio[best[1:0]] > s_next.prio[s_next.active_input_code]) begin
          s_next.active_input_code = best[1:0];
        end
        s_next.ref_valid_live = s_next.input_valid_live[s_next.active_input_code];
      end
      default: begin
        case (s_reg.fsm)
          RSH_COUNT: begin
            if (vtick) begin
              if (s_reg.pre_cnt + `RSH_PRE_W'(1) >= s_reg.holdoff_prescale) begin
                s_next.pre_cnt = '0;
                if (s_reg.hold_cnt == 8'h0) begin
                  expire = 1'b1;
                end else begin
                  s_next.hold_cnt = s_reg.hold_cnt - 8'h01;
                end
              end else begin
                s_next.pre_cnt = s_reg.pre_cnt + `RSH_PRE_W'(1);
              end
            end
            if (expire) begin
              s_next.hold_cnt = s_reg.holdoff_start_value;
              if (s_next.input_valid_live[s_reg.active_input_code]) begin
                s_next.fsm = RSH_RUN;
                s_next.ref_valid_live = 1'b1;
              end else if (best[2]) begin
                s_next.active_input_code = best[1:0];
                s_next.fsm = RSH_RUN;
                s_next.ref_valid_live = 1'b1;
              end else begin
                s_next.fsm = RSH_LOST;
              end
            end
          end
          RSH_LOST: begin
            if (best[2]) begin
              s_next.active_input_code = best[1:0];
              s_next.fsm = RSH_RUN;
              s_next.ref_valid_live = 1'b1;
            end
          end
          default: begin
            s_next.fsm = RSH_RUN;
            if (!s_next.input_valid_live[s_reg.active_input_code]) begin
              s_next.fsm = RSH_COUNT;
              s_next.ref_valid_live = 1'b0;
              s_next.hold_cnt = s_reg.holdoff_start_value;
              s_next.pre_cnt = '0;
            end else begin
              s_next.ref_valid_live = 1'b1;
              if (best[2] && (prio_wr || (s_reg.revert_enable && (|(reval & ~(4'h1 << s_reg.active_input_code)))))
                  && s_next.prio[best[1:0]] > s_next.prio[s_reg.active_input_code]) begin
                s_next.active_input_code = best[1:0];
              end
            end
          end
        endcase
      end
    endcase

    // reference sticky loss, clear refused while no valid reference
    if (bus.wr && bus.addr == `RSH_OFF_STICKY && bus.wdata[`RSH_SK_REF] && s_next.ref_valid_live) begin
      s_next.ref_loss_sticky = 1'b0;
    end
    if (s_reg.ref_valid_live && !s_next.ref_valid_live) begin
      s_next.ref_loss_sticky = 1'b1;
    end

    // ****************************************
    // lock detector
    // ****************************************
    if (ref_edge) begin
      s_next.fb_since_ref = 7'h0;
      if (s_reg.ref_since_fb != 7'h7f) begin
        s_next.ref_since_fb = s_reg.ref_since_fb + 7'h01;
      end
      if (s_reg.ref_since_fb >= win_bound(s_reg.window_start_setting)) begin
        s_next.vcxo_lock_lost_live = 1'b1;
      end
    end
    if (fb_edge) begin
      s_next.ref_since_fb = 7'h0;
      if (!ref_edge && s_reg.fb_since_ref != 7'h7f) begin
        s_next.fb_since_ref = s_reg.fb_since_ref + 7'h01;
      end
      s_next.vcxo_lock_lost_live = !(ref_edge || s_reg.fb_since_ref < win_bound(s_reg.window_end_setting));
    end
    if (s_next.vcxo_lock_lost_live) begin
      s_next.vcxo_lock_lost_sticky = 1'b1;
    end
    s_next.synth_lock_lost_live = pins.synth_lock_lost;
    if (pins.synth_lock_lost) begin
      s_next.synth_lock_lost_sticky = 1'b1;
    end

    // ****************************************
    // pins and read data
    // ****************************************
    // masked lock reporting
    s_next.lock_q = !(s_next.vcxo_lock_lost_live && !s_next.vcxo_lock_report_mask)
                    && !(s_next.synth_lock_lost_live && !s_next.synth_lock_report_mask);
    s_next.int_n_q = !(s_next.synth_lock_lost_sticky || s_next.vcxo_lock_lost_sticky
                       || s_next.ref_loss_sticky || (|s_next.input_loss_sticky));
    s_next.freeze_q = (s_next.fsm != RSH_RUN);
    case (bus.addr)
      `RSH_OFF_CTRL: rd_word = {25'h0, s_reg.synth_lock_report_mask, s_reg.vcxo_lock_report_mask,
                                s_reg.revert_enable, s_reg.man_sel, s_reg.mode};
      `RSH_OFF_PRIO: rd_word = {24'h0, s_reg.prio};
      `RSH_OFF_HOLDOFF: rd_word = {8'h0, s_reg.holdoff_prescale, s_reg.holdoff_start_value};
      `RSH_OFF_LOCKCFG: rd_word = {17'h0, s_reg.window_end_setting, 1'b0, s_reg.window_start_setting,
                                   s_reg.revalidation_count};
      `RSH_OFF_STATUS: rd_word = {8'h0, s_reg.hold_cnt, 6'h0, s_reg.synth_lock_lost_live,
                                  s_reg.vcxo_lock_lost_live, s_reg.freeze_q, s_reg.active_input_code,
                                  s_reg.ref_valid_live, s_reg.input_valid_live};
      `RSH_OFF_STICKY: rd_word = {25'h0, s_reg.synth_lock_lost_sticky, s_reg.vcxo_lock_lost_sticky,
                                  s_reg.ref_loss_sticky, s_reg.input_loss_sticky};
      default: rd_word = 32'h0;
    endcase
    s_next.rdata = bus.rd ? rd_word : 32'h0;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.revert_enable <= 1'b0;
      s_reg.holdoff_prescale <= `RSH_RST_PRESCALE;
      s_reg.holdoff_start_value <= `RSH_RST_START;
      s_reg.revalidation_count <= `RSH_RST_REVAL;
      s_reg.window_start_setting <= `RSH_RST_WINDOW;
      s_reg.window_end_setting <= `RSH_RST_WINDOW;
      s_reg.int_n_q <= 1'b1;
      s_reg.lock_q <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign active_input_code = s_reg.active_input_code;
  assign holdover_freeze = s_reg.freeze_q;
  assign lock_pin = s_reg.lock_q;
  assign interrupt_pin_n = s_reg.int_n_q;

endmodule : rsh_ctrl

/* File: rsh_ref_source.sv */
// model of the four reference sources and the loop clocks around the block
`timescale 1ns/1ps
module rsh_ref_source (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // controls from the bench
  input wire logic [3:0] src_on,
  input wire logic fb_on,
  input wire logic [1:0] fb_sel,
  input wire logic synth_lost,
  // pins toward the block
  output rsh_pkg::rsh_pins_type pins
);
  import rsh_pkg::*;
  logic [1:0] phase_reg;
  // *****
  // a stopped source holds a static level, the loss condition
  // *****
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 2'h0;
      pins <= '0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      for (int i = 0; i < 4; i++) begin
        if (src_on[i]) begin
          pins.clk_in[i] <= phase_reg[1];
        end
      end
      pins.los_ref_tick <= phase_reg[1] ^ phase_reg[0];
      pins.vcxo_tick <= ~pins.vcxo_tick;
      if (fb_on) begin
        pins.feedback_edge <= pins.clk_in[fb_sel];
      end
      pins.synth_lock_lost <= synth_lost;
    end
  end
endmodule : rsh_ref_source

/* File: rsh_ctrl_assertions.sv */
// port assertions of the reference select block
`timescale 1ns/1ps
`include "rsh_map.svh"
module rsh_ctrl_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire rsh_pkg::rsh_bus_type bus,
  input wire logic [31:0] rdata,
  // reference side and status pins
  input wire rsh_pkg::rsh_pins_type pins,
  input wire logic [1:0] active_input_code,
  input wire logic holdover_freeze,
  input wire logic lock_pin,
  input wire logic interrupt_pin_n
);
  import rsh_pkg::*;
  logic [6:0] ctrl_reg;
  logic ctrl_wr;
  logic st_rd;
  assign ctrl_wr = bus.wr && (bus.addr == `RSH_OFF_CTRL);
  assign st_rd = bus.rd && (bus.addr == `RSH_OFF_STATUS);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= 7'h00;
    end else if (ctrl_wr) begin
      ctrl_reg <= bus.wdata[6:0];
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // *****
  // assertions
  // *****
  a_manual_follow: assert property (ctrl_wr && bus.wdata[1:0] == 2'h0 |=>
    active_input_code == $past(bus.wdata[3:2])) else $error("manual select not followed");
  a_short_stable: assert property (ctrl_reg[1:0] == 2'h2 && !$past(ctrl_wr) |->
    $stable(active_input_code)) else $error("short holdover changed selection");
  a_hold_stable: assert property (ctrl_reg[1:0] == 2'h3 && !$past(ctrl_wr) && holdover_freeze
    && $past(holdover_freeze) |-> $stable(active_input_code)) else $error("selection moved in countdown");
  a_hold_entry: assert property ($rose(holdover_freeze) |-> ##[0:1] !interrupt_pin_n)
    else $error("holdover entered without sticky flag");
  a_synth_lock: assert property (pins.synth_lock_lost && !ctrl_reg[6] && !ctrl_wr |-> ##[1:3] !lock_pin)
    else $error("synth loss not on lock pin");
  a_vcxo_mask: assert property ((ctrl_reg[5] && !pins.synth_lock_lost) [*4] |-> lock_pin)
    else $error("masked vcxo loss reached lock pin");
  a_status_sel: assert property ($past(st_rd) |-> rdata[6:5] == $past(active_input_code))
    else $error("status selection field wrong");
  a_status_hold: assert property ($past(st_rd) |-> rdata[7] == $past(holdover_freeze))
    else $error("status holdover bit wrong");
  a_lock_flag: assert property ($fell(lock_pin) |-> ##[0:2] !interrupt_pin_n)
    else $error("lock loss without sticky flag");
  c_hold_in: cover property ($rose(holdover_freeze));
  c_hold_out: cover property ($fell(holdover_freeze));
  c_lock_lost: cover property ($fell(lock_pin));
endmodule : rsh_ctrl_assertions

bind rsh_ctrl rsh_ctrl_assertions chk (
  .clk(clk),
  .rst_n(rst_n),
  .bus(bus),
  .rdata(rdata),
  .pins(pins),
  .active_input_code(active_input_code),
  .holdover_freeze(holdover_freeze),
  .lock_pin(lock_pin),
  .interrupt_pin_n(interrupt_pin_n)
);

/* File: rsh_ctrl_test.sv */
// self-checking bench of the reference select and holdover block
`timescale 1ns/1ps
`include "rsh_map.svh"
module rsh_ctrl_test;
  import rsh_pkg::*;
  logic clk;
  logic rst_n;
  rsh_bus_type bus;
  logic [31:0] rdata;
  rsh_pins_type pins;
  logic [1:0] active_input_code;
  logic holdover_freeze;
  logic lock_pin;
  logic interrupt_pin_n;
  logic [3:0] src_on;
  logic fb_on;
  logic synth_lost;
  logic [31:0] rd_val;
  int n_errors;
  int check_count;
  int prio[4];
  int exp_sel;
  int old;
  int pword;
  logic [7:0] reg_off[4] = '{`RSH_OFF_CTRL, `RSH_OFF_HOLDOFF, `RSH_OFF_LOCKCFG, 8'h20};
  logic [31:0] reg_exp[4] = '{32'h0, 32'h100, 32'h7704, 32'h0};

  rsh_ctrl uut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .pins(pins),
    .active_input_code(active_input_code), .holdover_freeze(holdover_freeze), .lock_pin(lock_pin),
    .interrupt_pin_n(interrupt_pin_n));
  rsh_ref_source src_m (.clk(clk), .rst_n(rst_n), .src_on(src_on), .fb_on(fb_on),
    .fb_sel(active_input_code), .synth_lost(synth_lost), .pins(pins));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // *****
  // tasks and reference model
  // *****
  task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk_word
  task automatic chk_pin(input string what, input logic [1:0] e, input logic [1:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk_pin
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input int d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= 32'(d);
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    rd_val = rdata;
  endtask : rd
  task automatic src(input logic [3:0] on);
    @(posedge clk);
    src_on <= on;
  endtask : src
  function automatic logic out_bit(input int w);
    return (w == 0) ? holdover_freeze : (w == 1) ? lock_pin : interrupt_pin_n;
  endfunction : out_bit
  task automatic wait_out(input string what, input int w, input logic v, input int lim);
    for (int i = 0; i < lim && out_bit(w) !== v; i++) @(posedge clk) #1;
    chk_pin(what, {1'b0, v}, {1'b0, out_bit(w)});
    if (out_bit(w) !== v) conclude();
  endtask : wait_out
  function automatic int best(input logic [3:0] valid);
    int b;
    b = -1;
    for (int i = 0; i < 4; i++) if (valid[i] && (b < 0 || prio[i] > prio[b])) b = i;
    return b;
  endfunction : best
  task automatic sel_is(input string what);
    #1;
    chk_pin(what, 2'(exp_sel), active_input_code);
  endtask : sel_is

  // *****
  // main sequence
  // *****
  initial begin
    bus = '0;
    rst_n = 1'b0;
    src_on = 4'h0;
    fb_on = 1'b1;
    synth_lost = 1'b0;
    n_errors = 0;
    check_count = 0;
    exp_sel = 0;
    rd_val = $urandom(22);
    repeat (16) @(posedge clk);
    #1;
    sel_is("reset active_input_code");
    chk_pin("reset outputs", 2'h1, {holdover_freeze, lock_pin & interrupt_pin_n});
    @(posedge clk);
    rst_n <= 1'b1;
    foreach (reg_off[i]) begin
      rd(reg_off[i]);
      chk_word("reset register", reg_exp[i], rd_val);
    end
    wr(`RSH_OFF_LOCKCFG, 32'h2204);
    src(4'hf);
    repeat (40) @(posedge clk);
    rd(`RSH_OFF_STATUS);
    chk_word("input_valid_live", 32'hf, rd_val & 32'hf);
    $display("test reset finished");
    for (int s = 0; s < 4; s++) begin
      exp_sel = s;
      wr(`RSH_OFF_CTRL, s << 2);
      sel_is("manual select");
    end
    pword = 0;
    foreach (prio[i]) begin
      prio[i] = $urandom_range(3, 0);
      pword |= prio[i] << (2 * i);
    end
    wr(`RSH_OFF_PRIO, pword);
    exp_sel = best(4'hf);
    old = exp_sel;
    wr(`RSH_OFF_CTRL, exp_sel << 2);
    wr(`RSH_OFF_CTRL, (exp_sel << 2) | 1);
    src(4'hf & ~(4'h1 << old));
    repeat (30) @(posedge clk);
    exp_sel = best(4'hf & ~(4'h1 << old));
    sel_is("auto failover");
    src(4'hf);
    repeat (40) @(posedge clk);
    sel_is("no revert");
    wr(`RSH_OFF_STICKY, 32'h7f);
    wr(`RSH_OFF_CTRL, 32'h11);
    src(4'hf & ~(4'h1 << old));
    repeat (30) @(posedge clk);
    src(4'hf);
    repeat (40) @(posedge clk);
    if (prio[old] > prio[exp_sel]) exp_sel = old;
    sel_is("revert");
    prio[exp_sel] = 0;
    prio[(exp_sel + 1) % 4] = 3;
    pword = 0;
    foreach (prio[i]) pword |= prio[i] << (2 * i);
    wr(`RSH_OFF_PRIO, pword);
    repeat (2) @(posedge clk);
    exp_sel = best(4'hf);
    sel_is("priority change");
    $display("test auto finished");
    wr(`RSH_OFF_STICKY, 32'h7f);
    wr(`RSH_OFF_HOLDOFF, 32'h0203);
    wr(`RSH_OFF_CTRL, (exp_sel << 2) | 32'h13);
    old = exp_sel;
    src(4'hf & ~(4'h1 << old));
    wait_out("freeze on loss", 0, 1'b1, 40);
    chk_pin("interrupt_pin_n", 2'h0, {1'b0, interrupt_pin_n});
    sel_is("holdover selection");
    wait_out("freeze after countdown", 0, 1'b0, 300);
    exp_sel = best(4'hf & ~(4'h1 << old));
    sel_is("expiry reselect");
    rd(`RSH_OFF_STATUS);
    chk_word("ref valid and holdover", 32'h10, rd_val & 32'h90);
    src(4'hf);
    repeat (40) @(posedge clk);
    if (prio[old] > prio[exp_sel]) exp_sel = old;
    sel_is("revert after countdown");
    wr(`RSH_OFF_STICKY, 32'h7f);
    wr(`RSH_OFF_HOLDOFF, 32'h0440);
    src(4'hf & ~(4'h1 << exp_sel));
    wait_out("freeze on loss", 0, 1'b1, 40);
    src(4'hf);
    repeat (60) @(posedge clk);
    chk_pin("freeze during countdown", 2'h1, {1'b0, holdover_freeze});
    sel_is("selection during countdown");
    wait_out("freeze after countdown", 0, 1'b0, 1000);
    sel_is("revalidated kept");
    wr(`RSH_OFF_STICKY, 32'h7f);
    wr(`RSH_OFF_HOLDOFF, 32'h0202);
    src(4'h0);
    wait_out("freeze on loss", 0, 1'b1, 40);
    repeat (200) @(posedge clk);
    chk_pin("no valid input", 2'h1, {1'b0, holdover_freeze});
    sel_is("no valid selection");
    wr(`RSH_OFF_STICKY, 32'h10);
    rd(`RSH_OFF_STICKY);
    chk_word("ref sticky kept", 32'h10, rd_val & 32'h10);
    src(4'hf);
    wait_out("freeze on return", 0, 1'b0, 100);
    exp_sel = best(4'hf);
    sel_is("first valid taken");
    $display("test holdover finished");
    wr(`RSH_OFF_STICKY, 32'h7f);
    exp_sel = $urandom_range(3, 0);
    wr(`RSH_OFF_CTRL, (exp_sel << 2) | 2);
    src(4'hf & ~(4'h1 << exp_sel));
    wait_out("short freeze", 0, 1'b1, 40);
    sel_is("short selection");
    rd(`RSH_OFF_STATUS);
    chk_word("short ref valid", 32'h0, rd_val & 32'h10);
    src(4'hf);
    wait_out("short release", 0, 1'b0, 60);
    rd(`RSH_OFF_STATUS);
    chk_word("short ref valid", 32'h10, rd_val & 32'h10);
    $display("test short holdover finished");
    wr(`RSH_OFF_CTRL, 0);
    repeat (20) @(posedge clk);
    wr(`RSH_OFF_STICKY, 32'h7f);
    wait_out("locked", 1, 1'b1, 40);
    @(posedge clk);
    fb_on <= 1'b0;
    wait_out("vcxo lock lost", 1, 1'b0, 60);
    rd(`RSH_OFF_STATUS);
    chk_word("vcxo lost live", 32'h100, rd_val & 32'h100);
    wr(`RSH_OFF_CTRL, 32'h20);
    wait_out("vcxo masked", 1, 1'b1, 10);
    @(posedge clk);
    synth_lost <= 1'b1;
    wait_out("synth lock lost", 1, 1'b0, 10);
    wr(`RSH_OFF_CTRL, 32'h60);
    wait_out("synth masked", 1, 1'b1, 10);
    @(posedge clk);
    synth_lost <= 1'b0;
    fb_on <= 1'b1;
    repeat (40) @(posedge clk);
    wr(`RSH_OFF_CTRL, 0);
    wr(`RSH_OFF_STICKY, 32'h7f);
    wait_out("sticky cleared", 2, 1'b1, 10);
    $display("test lock finished");
    conclude();
  end
endmodule : rsh_ctrl_test
